// *** src/medc_top.sv ***
// Module: motion event detection, status flags and interrupt pin control
// Operation
// R1: Pin A polarity bit 2: 0 active low, 1 active high.
// R2: Pin A mode bit 3: 0 open drain, 1 push-pull.
// R3: Pin B polarity bit 6; in general-purpose mode it sets driven level.
// R4: Pin B mode bit 7: 0 open drain, 1 push-pull.
// R5: Fifteen-bit tilt threshold from 0x40 and seven bits of 0x41.
// R6: Sample above tilt threshold gives tilt condition.
// R7: Below threshold gives flat or flip by Z sign and orientation bit.
// R8: Tilt detection sets tilt-35 flag, status bit 4.
// R9: Tilt/flip flags set once condition outlasts the eight-bit debounce.
// R10: Any axis sample change above motion threshold is a motion condition.
// R11: Motion condition sets status bit 2.
// R12: Motion flag clears after debounce samples without motion.
// R13: Status write clears all, or per-bit mask when per-bit mode on.
// R14: Pin swap bit routes first request to pin B and second to A.
// R15: Debounce counts in samples, restarting when the condition begins anew.
module medc_top
   import medc_pkg::*;
(
   input  wire logic                     ref_clk,
   input  wire logic                     resetn,
   input  wire logic                     reg_wr_en,
   input  wire logic [7:0]               reg_addr,
   input  wire logic [7:0]               reg_wdata,
   input  wire logic                     sample_valid,
   input  wire logic [medc_pkg::SMP_W-1:0] x_sample,
   input  wire logic [medc_pkg::SMP_W-1:0] y_sample,
   input  wire logic [medc_pkg::SMP_W-1:0] z_sample,
   input  wire logic                     z_orient,
   input  wire logic                     pin_b_gpio_mode,
   output logic [7:0]                    irq_status,
   output logic                          irq_pin_a_o,
   output logic                          irq_pin_a_oe,
   output logic                          irq_pin_b_o,
   output logic                          irq_pin_b_oe
);
   import medc_pkg::*;

   // ****************************************************************
   // Helpers
   // ****************************************************************
   function automatic logic [SMP_W:0] abs_val(input logic signed [SMP_W:0] v);
      abs_val = v[SMP_W] ? (SMP_W+1)'(-v) : (SMP_W+1)'(v);
   endfunction

   function automatic logic [SMP_W:0] abs_diff(input logic [SMP_W-1:0] a, input logic [SMP_W-1:0] b);
      logic signed [SMP_W:0] d;
      d = $signed({a[SMP_W-1], a}) - $signed({b[SMP_W-1], b});
      abs_diff = abs_val(d);
   endfunction

   // ****************************************************************
   // Reset release
   // ****************************************************************
   logic rst_meta_ff;
   logic rst_n_ff;

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rst_meta_ff <= 1'b0;
         rst_n_ff    <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_n_ff    <= rst_meta_ff;
      end
   end

   // ****************************************************************
   // Write-only registers
   // ****************************************************************
   logic [7:0]       pin_cfg_ff;
   logic [7:0]       tilt_thr_lo_ff;
   logic [6:0]       tilt_thr_hi_ff;
   logic [7:0]       tilt_db_ff;
   logic [7:0]       mot_thr_lo_ff;
   logic [6:0]       mot_thr_hi_ff;
   logic [7:0]       mot_db_ff;
   logic             irq_pin_swap_ff;
   logic             per_bit_irq_clear_ff;
   logic [THR_W-1:0] tilt_threshold;
   logic [THR_W-1:0] motion_threshold;

   always_ff @(posedge ref_clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         pin_cfg_ff           <= RST_BYTE;
         tilt_thr_lo_ff       <= RST_BYTE;
         tilt_thr_hi_ff       <= RST_HI7;
         tilt_db_ff           <= RST_BYTE;
         mot_thr_lo_ff        <= RST_BYTE;
         mot_thr_hi_ff        <= RST_HI7;
         mot_db_ff            <= RST_BYTE;
         irq_pin_swap_ff      <= 1'b0;
         per_bit_irq_clear_ff <= 1'b0;
      end else if (reg_wr_en) begin
         unique case (reg_addr)
            ADDR_IRQ_PIN_CFG: pin_cfg_ff     <= reg_wdata;
            ADDR_TILT_THR_LO: tilt_thr_lo_ff <= reg_wdata; // R5
            ADDR_TILT_THR_HI: tilt_thr_hi_ff <= reg_wdata[6:0]; // R5
            ADDR_TILT_DB:     tilt_db_ff     <= reg_wdata;
            ADDR_MOT_THR_LO:  mot_thr_lo_ff  <= reg_wdata;
            ADDR_MOT_THR_HI:  mot_thr_hi_ff  <= reg_wdata[6:0];
            ADDR_MOT_DB:      mot_db_ff      <= reg_wdata;
            ADDR_COMM_CTRL: begin
               irq_pin_swap_ff      <= reg_wdata[COMM_SWAP_BIT];
               per_bit_irq_clear_ff <= reg_wdata[COMM_PBC_BIT];
            end
            default: ;
         endcase
      end
   end

   assign tilt_threshold   = {tilt_thr_hi_ff, tilt_thr_lo_ff}; // R5
   assign motion_threshold = {mot_thr_hi_ff, mot_thr_lo_ff};

   // ****************************************************************
   // Position classification
   // ****************************************************************
   logic [SMP_W:0] x_mag;
   logic [SMP_W:0] y_mag;
   logic [SMP_W:0] tilt_metric;
   logic           is_tilt;
   medc_pos_e      nxt_pos;

   assign x_mag       = abs_val($signed({x_sample[SMP_W-1], x_sample}));
   assign y_mag       = abs_val($signed({y_sample[SMP_W-1], y_sample}));
   assign tilt_metric = (x_mag > y_mag) ? x_mag : y_mag;
   assign is_tilt     = tilt_metric > {2'b00, tilt_threshold}; // R6

   // Face orientation picks flat against flip
   always_comb begin
      if (is_tilt) begin
         nxt_pos = POS_TILT; // R6
      end else if (z_sample[SMP_W-1] == z_orient) begin
         nxt_pos = POS_FLAT; // R7
      end else begin
         nxt_pos = POS_FLIP; // R7
      end
   end

   // ****************************************************************
   // Tilt/flip debounce
   // ****************************************************************
   medc_pos_e pos_ff;
   logic [7:0] tf_cnt_ff;
   logic       tf_fired_ff;
   logic       tf_fire;
   logic       tilt35_set;

   // Count saturates so a long hold cannot wrap and re-fire
   always_ff @(posedge ref_clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         pos_ff      <= POS_FLAT;
         tf_cnt_ff   <= RST_BYTE;
         tf_fired_ff <= 1'b0;
      end else if (sample_valid) begin
         if (nxt_pos != pos_ff) begin
            pos_ff      <= nxt_pos;
            tf_cnt_ff   <= RST_BYTE; // R15
            tf_fired_ff <= 1'b0;
         end else begin
            if (tf_cnt_ff != CNT_MAX) begin
               tf_cnt_ff <= tf_cnt_ff + 8'h01; // R15
            end
            if (tf_fire) begin
               tf_fired_ff <= 1'b1;
            end
         end
      end
   end

   // Same state on this sample means it has lasted count+2 samples
   assign tf_fire    = sample_valid && (nxt_pos == pos_ff) && !tf_fired_ff
                       && (pos_ff != POS_FLAT) && (tf_cnt_ff >= tilt_db_ff); // R9
   assign tilt35_set = sample_valid && is_tilt && (pos_ff != POS_TILT); // R8

   // ****************************************************************
   // Any-motion detection
   // ****************************************************************
   logic [SMP_W-1:0] x_prev_ff;
   logic [SMP_W-1:0] y_prev_ff;
   logic [SMP_W-1:0] z_prev_ff;
   logic             have_prev_ff;
   logic [7:0]       mot_quiet_ff;
   logic             motion_hit;
   logic             mot_auto_clr;
   logic [SMP_W:0]   mot_lim;

   assign mot_lim    = {2'b00, motion_threshold};
   assign motion_hit = sample_valid && have_prev_ff
                       && ((abs_diff(x_sample, x_prev_ff) > mot_lim)
                        || (abs_diff(y_sample, y_prev_ff) > mot_lim)
                        || (abs_diff(z_sample, z_prev_ff) > mot_lim)); // R10

   always_ff @(posedge ref_clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         x_prev_ff    <= '0;
         y_prev_ff    <= '0;
         z_prev_ff    <= '0;
         have_prev_ff <= 1'b0;
      end else if (sample_valid) begin
         x_prev_ff    <= x_sample;
         y_prev_ff    <= y_sample;
         z_prev_ff    <= z_sample;
         have_prev_ff <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         mot_quiet_ff <= RST_BYTE;
      end else if (motion_hit) begin
         mot_quiet_ff <= RST_BYTE; // R15
      end else if (sample_valid && mot_quiet_ff != CNT_MAX) begin
         mot_quiet_ff <= mot_quiet_ff + 8'h01; // R15
      end
   end

   // Quiet samples counted including this one reach the duration
   assign mot_auto_clr = sample_valid && !motion_hit && irq_status[ST_MOTION]
                         && ({1'b0, mot_quiet_ff} + 9'h001 >= {1'b0, mot_db_ff}); // R12

   // ****************************************************************
   // Status flags
   // ****************************************************************
   logic [7:0] flag_set;
   logic [7:0] flag_clr;
   logic [7:0] nxt_status;
   logic       host_clr;

   assign host_clr = reg_wr_en && (reg_addr == ADDR_IRQ_STATUS);

   always_comb begin
      flag_set            = 8'h00;
      flag_set[ST_TILT]   = tf_fire && (pos_ff == POS_TILT); // R9
      flag_set[ST_FLIP]   = tf_fire && (pos_ff == POS_FLIP); // R9
      flag_set[ST_MOTION] = motion_hit; // R11
      flag_set[ST_TILT35] = tilt35_set; // R8
      flag_clr            = 8'h00;
      if (host_clr) begin
         flag_clr = per_bit_irq_clear_ff ? reg_wdata : 8'hFF; // R13
      end
      flag_clr[ST_MOTION] = flag_clr[ST_MOTION] | mot_auto_clr; // R12
      // A new event outranks a clear in the same cycle
      nxt_status = (irq_status & ~flag_clr) | flag_set;
   end

   always_ff @(posedge ref_clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         irq_status <= RST_BYTE;
      end else begin
         irq_status <= nxt_status;
      end
   end

   // ****************************************************************
   // Interrupt pins
   // ****************************************************************
   logic req_first;
   logic req_second;
   logic pin_a_req;
   logic pin_b_req;

   assign req_first  = irq_status[ST_TILT] | irq_status[ST_FLIP] | irq_status[ST_TILT35];
   assign req_second = irq_status[ST_MOTION];
   assign pin_a_req  = irq_pin_swap_ff ? req_second : req_first; // R14
   assign pin_b_req  = irq_pin_swap_ff ? req_first : req_second; // R14

   medc_pin_drv u_pin_a (
      .clk         (ref_clk),
      .rst_n       (rst_n_ff),
      .req         (pin_a_req),
      .active_high (pin_cfg_ff[PIN_A_AH_BIT]), // R1
      .push_pull   (pin_cfg_ff[PIN_A_PP_BIT]), // R2
      .gpio_mode   (1'b0),
      .pin_o       (irq_pin_a_o),
      .pin_oe      (irq_pin_a_oe)
   );

   medc_pin_drv u_pin_b (
      .clk         (ref_clk),
      .rst_n       (rst_n_ff),
      .req         (pin_b_req),
      .active_high (pin_cfg_ff[PIN_B_AH_BIT]), // R3
      .push_pull   (pin_cfg_ff[PIN_B_PP_BIT]), // R4
      .gpio_mode   (pin_b_gpio_mode),
      .pin_o       (irq_pin_b_o),
      .pin_oe      (irq_pin_b_oe)
   );

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n_ff);

   a_pin_a_low: assert property (!pin_cfg_ff[PIN_A_AH_BIT] && pin_cfg_ff[PIN_A_PP_BIT] && !irq_pin_swap_ff
                                 |=> irq_pin_a_o == !$past(req_first)) // R1
      else $error("pin A active-low level wrong");
   a_swap_route: assert property (irq_pin_swap_ff && pin_cfg_ff[PIN_A_AH_BIT] && pin_cfg_ff[PIN_A_PP_BIT]
                                  |=> irq_pin_a_o == $past(req_second)) // R14
      else $error("swapped request not on pin A");
   a_thr_write: assert property (reg_wr_en && reg_addr == ADDR_TILT_THR_HI
                                 |=> tilt_threshold[14:8] == $past(reg_wdata[6:0])) // R5
      else $error("tilt threshold high bits not loaded");
   a_tilt_state: assert property (sample_valid && is_tilt |=> pos_ff == POS_TILT) // R6
      else $error("tilt condition not taken");
   a_flat_pick: assert property (sample_valid && !is_tilt && z_sample[SMP_W-1] == z_orient
                                 |=> pos_ff == POS_FLAT) // R7
      else $error("flat condition not taken");
   a_tilt35_flag: assert property (tilt35_set |=> irq_status[ST_TILT35]) // R8
      else $error("tilt-35 flag not set");
   a_tf_debounce: assert property ($rose(irq_status[ST_TILT]) || $rose(irq_status[ST_FLIP])
                                   |-> $past(tf_cnt_ff) >= $past(tilt_db_ff)) // R9
      else $error("tilt/flip flag set before debounce");
   a_motion_flag: assert property (motion_hit |=> irq_status[ST_MOTION]) // R11
      else $error("motion flag not set");
   a_motion_quiet: assert property (mot_auto_clr |=> !irq_status[ST_MOTION]) // R12
      else $error("motion flag not cleared after quiet time");
   a_clear_all: assert property (host_clr && !per_bit_irq_clear_ff && flag_set == 8'h00
                                 |=> irq_status == 8'h00) // R13
      else $error("status write did not clear all");
   a_count_restart: assert property (sample_valid && nxt_pos != pos_ff |=> tf_cnt_ff == 8'h00) // R15
      else $error("debounce count not restarted");

   c_tilt_fire:   cover property (tf_fire && pos_ff == POS_TILT);
   c_flip_fire:   cover property (tf_fire && pos_ff == POS_FLIP);
   c_motion_clr:  cover property (mot_auto_clr);
   c_perbit_clr:  cover property (host_clr && per_bit_irq_clear_ff);
endmodule

// *** src/medc_pkg.sv ***
// Package: register map, field positions and position states of the motion event block
package medc_pkg;

   // ****************************************************************
   // Register offsets
   // ****************************************************************
   localparam logic [7:0] ADDR_IRQ_STATUS   = 8'h14;
   localparam logic [7:0] ADDR_COMM_CTRL    = 8'h31;
   localparam logic [7:0] ADDR_IRQ_PIN_CFG  = 8'h33;
   localparam logic [7:0] ADDR_TILT_THR_LO  = 8'h40;
   localparam logic [7:0] ADDR_TILT_THR_HI  = 8'h41;
   localparam logic [7:0] ADDR_TILT_DB      = 8'h42;
   localparam logic [7:0] ADDR_MOT_THR_LO   = 8'h43;
   localparam logic [7:0] ADDR_MOT_THR_HI   = 8'h44;
   localparam logic [7:0] ADDR_MOT_DB       = 8'h45;

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [7:0] RST_BYTE          = 8'h00;
   localparam logic [6:0] RST_HI7           = 7'h00;
   localparam logic [7:0] CNT_MAX           = 8'hFF;

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int PIN_A_AH_BIT  = 2;
   localparam int PIN_A_PP_BIT  = 3;
   localparam int PIN_B_AH_BIT  = 6;
   localparam int PIN_B_PP_BIT  = 7;
   localparam int COMM_SWAP_BIT = 4;
   localparam int COMM_PBC_BIT  = 6;
   localparam int ST_TILT       = 0;
   localparam int ST_FLIP       = 1;
   localparam int ST_MOTION     = 2;
   localparam int ST_TILT35     = 4;
   localparam int THR_W         = 15;
   localparam int SMP_W         = 16;

   // ****************************************************************
   // Position states
   // ****************************************************************
   typedef enum logic [2:0] {
      POS_FLAT = 3'b001,
      POS_TILT = 3'b010,
      POS_FLIP = 3'b100
   } medc_pos_e;

endpackage

// *** src/medc_pin_drv.sv ***
// Module: drive stage of one interrupt request pin, polarity and drive mode
module medc_pin_drv (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic req,
   input  wire logic active_high,
   input  wire logic push_pull,
   input  wire logic gpio_mode,
   output logic      pin_o,
   output logic      pin_oe
);
   logic level;

   // In general-purpose mode the polarity bit is the driven level
   assign level = gpio_mode ? active_high : (req ? active_high : ~active_high);

   // Open drain only ever pulls low; high comes from the external pull-up
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_o  <= 1'b0;
         pin_oe <= 1'b0;
      end else if (push_pull) begin
         pin_o  <= level;
         pin_oe <= 1'b1;
      end else begin
         pin_o  <= 1'b0;
         pin_oe <= ~level;
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_od_low_only: assert property (!push_pull |=> !pin_o && (pin_oe == !$past(level))) // R2
      else $error("open-drain pin drove high or wrong enable");
   a_pp_drives: assert property (push_pull |=> pin_oe && (pin_o == $past(level))) // R4
      else $error("push-pull pin not driven to level");
   a_gpio_level: assert property (gpio_mode && push_pull |=> pin_o == $past(active_high)) // R3
      else $error("gpio level does not follow polarity bit");
endmodule

// *** bench/medc_host.sv ***
// Host model: register writes and interrupt pin sensing with pull-ups
module medc_host
   import medc_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic       pin_a_o,
   input  wire logic       pin_a_oe,
   input  wire logic       pin_b_o,
   input  wire logic       pin_b_oe,
   output logic            reg_wr_en,
   output logic [7:0]      reg_addr,
   output logic [7:0]      reg_wdata,
   output logic            irq_pin_a,
   output logic            irq_pin_b
);
   timeunit 1ns;
   timeprecision 1ps;

   // ****************************************************************
   // Pin sensing
   // ****************************************************************
   // External pull-ups: a released line reads high
   assign irq_pin_a = pin_a_oe ? pin_a_o : 1'b1;
   assign irq_pin_b = pin_b_oe ? pin_b_o : 1'b1;

   // ****************************************************************
   // Register writes
   // ****************************************************************
   initial begin
      reg_wr_en = 1'b0;
      reg_addr  = 8'h00;
      reg_wdata = 8'h00;
   end

   // Strobe held across one rising edge, bus scrambled once released
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      reg_wr_en = 1'b1;
      reg_addr  = a;
      reg_wdata = d;
      @(negedge ref_clk);
      reg_wr_en = 1'b0;
      reg_addr  = ~a;
      reg_wdata = ~d;
   endtask

   // Mask only matters when per-bit clear is on
   task automatic clear_irq(input logic [7:0] mask);
      wr(ADDR_IRQ_STATUS, mask);
   endtask
endmodule

// *** bench/testbench.sv ***
// Testbench: motion event detection, status flags and interrupt pins
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import medc_pkg::*;

   logic             ref_clk = 1'b0;
   logic             resetn = 1'b0;
   logic             sample_valid = 1'b0;
   logic             z_orient = 1'b0;
   logic             pin_b_gpio_mode = 1'b0;
   logic [SMP_W-1:0] x_s = '0;
   logic [SMP_W-1:0] y_s = '0;
   logic [SMP_W-1:0] z_s = '0;
   logic             reg_wr_en;
   logic [7:0]       reg_addr;
   logic [7:0]       reg_wdata;
   logic [7:0]       irq_status;
   logic             pa_o, pa_oe, pb_o, pb_oe;
   logic             irq_pin_a, irq_pin_b;
   int               n_errors = 0;
   int               checked = 0;
   int               cycles = 0;

   always #25 ref_clk = ~ref_clk;

   medc_top uut (
      .ref_clk(ref_clk), .resetn(resetn), .reg_wr_en(reg_wr_en), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .sample_valid(sample_valid), .x_sample(x_s), .y_sample(y_s),
      .z_sample(z_s), .z_orient(z_orient), .pin_b_gpio_mode(pin_b_gpio_mode),
      .irq_status(irq_status), .irq_pin_a_o(pa_o), .irq_pin_a_oe(pa_oe),
      .irq_pin_b_o(pb_o), .irq_pin_b_oe(pb_oe)
   );

   medc_host host (
      .ref_clk(ref_clk), .pin_a_o(pa_o), .pin_a_oe(pa_oe), .pin_b_o(pb_o), .pin_b_oe(pb_oe),
      .reg_wr_en(reg_wr_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .irq_pin_a(irq_pin_a), .irq_pin_b(irq_pin_b)
   );

   // ****************************************************************
   // Helpers
   // ****************************************************************
   task automatic end_sim();
      if (n_errors == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // Whole run needs under two hundred cycles
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 3000) begin
         n_errors++;
         end_sim();
      end
   end

   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Results settle well within four cycles
   task automatic settle();
      repeat (4) @(negedge ref_clk);
   endtask

   task automatic smp(input int n, input logic [15:0] x, input logic [15:0] y, input logic [15:0] z);
      repeat (n) begin
         @(negedge ref_clk);
         sample_valid = 1'b1;
         x_s = x;
         y_s = y;
         z_s = z;
         @(negedge ref_clk);
         sample_valid = 1'b0;
      end
      settle();
   endtask

   task automatic chk_pins(input logic [1:0] a, input logic [1:0] b);
      chk("pin_a", {6'h00, pa_oe, pa_o}, {6'h00, a});
      chk("pin_b", {6'h00, pb_oe, pb_o}, {6'h00, b});
   endtask

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_reset();
      settle();
      chk("status", irq_status, 8'h00);
      chk("wire_a", {7'h00, irq_pin_a}, 8'h01);
      chk("wire_b", {7'h00, irq_pin_b}, 8'h01);
   endtask

   // Reserved bit 7 of the high byte must be dropped or nothing tilts
   task automatic t_tilt();
      host.wr(ADDR_TILT_THR_LO, 8'h00);
      host.wr(ADDR_TILT_THR_HI, 8'h90);
      host.wr(ADDR_TILT_DB, 8'h02);
      host.wr(ADDR_MOT_THR_LO, 8'hFF);
      host.wr(ADDR_MOT_THR_HI, 8'h7F);
      smp(1, 16'h1000, 16'h0000, 16'h0000);
      chk("status", irq_status, 8'h00);
      smp(1, 16'h0000, 16'hE000, 16'h0000);
      chk("status", irq_status, 8'h10);
      chk_pins(2'b10, 2'b00);
      chk("wire_a", {7'h00, irq_pin_a}, 8'h00);
      smp(2, 16'h0000, 16'hE000, 16'h0000);
      chk("status", irq_status, 8'h10);
      smp(1, 16'h0000, 16'hE000, 16'h0000);
      chk("status", irq_status, 8'h11);
   endtask

   task automatic t_motion();
      host.wr(ADDR_COMM_CTRL, 8'h40);
      host.wr(ADDR_MOT_THR_LO, 8'h00);
      host.wr(ADDR_MOT_THR_HI, 8'h01);
      host.wr(ADDR_MOT_DB, 8'h03);
      smp(1, 16'h0000, 16'hE300, 16'h0000);
      chk("status", irq_status, 8'h15);
      chk("wire_b", {7'h00, irq_pin_b}, 8'h00);
      host.clear_irq(8'h10);
      settle();
      chk("status", irq_status, 8'h05);
      smp(1, 16'h0000, 16'hE300, 16'h0000);
      chk("status", irq_status, 8'h05);
      smp(1, 16'h0000, 16'hE300, 16'h0000);
      chk("status", irq_status, 8'h05);
      smp(1, 16'h0000, 16'hE300, 16'h0000);
      chk("status", irq_status, 8'h01);
      // Change on X alone, then on Z alone, must each count as motion
      smp(1, 16'h0200, 16'hE300, 16'h0000);
      chk("status", irq_status, 8'h05);
      host.clear_irq(8'h04);
      smp(1, 16'h0200, 16'hE300, 16'h0200);
      chk("status", irq_status, 8'h05);
      host.clear_irq(8'h04);
      settle();
      chk("status", irq_status, 8'h01);
   endtask

   task automatic t_pins();
      host.wr(ADDR_IRQ_PIN_CFG, 8'hCC);
      settle();
      chk_pins(2'b11, 2'b10);
      host.wr(ADDR_COMM_CTRL, 8'h50);
      settle();
      chk_pins(2'b10, 2'b11);
      host.wr(ADDR_COMM_CTRL, 8'h00);
      pin_b_gpio_mode = 1'b1;
      settle();
      chk_pins(2'b11, 2'b11);
      host.wr(ADDR_IRQ_PIN_CFG, 8'h8C);
      settle();
      chk_pins(2'b11, 2'b10);
      pin_b_gpio_mode = 1'b0;
      host.wr(ADDR_IRQ_PIN_CFG, 8'h08);
      settle();
      chk_pins(2'b10, 2'b00);
   endtask

   // Flip when the Z sign differs from the orientation bit, flat otherwise
   task automatic t_flip();
      host.wr(8'h50, 8'hFF);
      host.wr(ADDR_MOT_THR_HI, 8'h7F);
      settle();
      chk("status", irq_status, 8'h01);
      host.clear_irq(8'h00);
      settle();
      chk("status", irq_status, 8'h00);
      smp(4, 16'h0000, 16'h0000, 16'hC000);
      chk("status", irq_status, 8'h02);
      z_orient = 1'b1;
      host.clear_irq(8'h00);
      smp(4, 16'h0000, 16'h0000, 16'hC000);
      chk("status", irq_status, 8'h00);
   endtask

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      repeat (3) @(negedge ref_clk);
      resetn = 1'b1;
      t_reset();
      t_tilt();
      t_motion();
      t_pins();
      t_flip();
      end_sim();
   end
endmodule
